// ===== hw/chan_fifo.sv
`timescale 1ns/100ps
module chan_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    chan_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_q, cptr_q, rptr_q, wptr_d;
    logic [CW-1:0] tent_q, avail_q, tent_d, avail_d;
    logic [W-1:0] dout_q;
    logic dvalid_q, space_q;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Writes stay invisible to the reader until committed; abort rolls them back
    wire do_wr = f.wr_valid && space_q && !f.abort;
    wire do_pop = (avail_q != '0) && (!dvalid_q || f.rd_ready);
    assign wptr_d = f.abort ? cptr_q : (do_wr ? bump(wptr_q) : wptr_q);
    assign tent_d = f.abort ? avail_q - CW'(do_pop) : tent_q + CW'(do_wr) - CW'(do_pop);
    assign avail_d = f.commit ? tent_d : avail_q - CW'(do_pop);
    assign f.wr_ready = space_q;
    assign f.rd_valid = dvalid_q;
    assign f.rd_data = dout_q;
    assign f.level = tent_q;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_q] <= f.wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_q <= '0;
            cptr_q <= '0;
            rptr_q <= '0;
            tent_q <= '0;
            avail_q <= '0;
            space_q <= 1'b0;
        end else if (f.flush) begin
            wptr_q <= '0;
            cptr_q <= '0;
            rptr_q <= '0;
            tent_q <= '0;
            avail_q <= '0;
            space_q <= 1'b0;
        end else begin
            wptr_q <= wptr_d;
            cptr_q <= f.commit ? wptr_d : cptr_q;
            rptr_q <= do_pop ? bump(rptr_q) : rptr_q;
            tent_q <= tent_d;
            avail_q <= avail_d;
            space_q <= tent_d < CW'(DEPTH);
        end
    end

    // Read data leave from a register so the consumer sees a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dvalid_q <= 1'b0;
            dout_q <= '0;
        end else if (f.flush) begin
            dvalid_q <= 1'b0;
        end else if (do_pop) begin
            dvalid_q <= 1'b1;
            dout_q <= mem[rptr_q];
        end else if (f.rd_ready) begin
            dvalid_q <= 1'b0;
        end
    end

    chk_commit_gate: assert property (@(posedge clk) disable iff (!resetn)
        (!f.commit && !f.flush) |=> avail_q <= $past(avail_q))
        else $error("fifo contents became visible without a commit");
endmodule

// ===== hw/chan_fifo_if.sv
`timescale 1ns/100ps
interface chan_fifo_if #(parameter int W = 8, parameter int CW = 5);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic commit;
    logic abort;
    logic flush;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic [CW-1:0] level;
    modport store(input wr_valid, wr_data, commit, abort, flush, rd_ready,
        output wr_ready, rd_valid, rd_data, level);
    modport user(output wr_valid, wr_data, commit, abort, flush, rd_ready,
        input wr_ready, rd_valid, rd_data, level);
endinterface

// ===== hw/uart_chan_pkg.sv
package uart_chan_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_RESET = 9600;
    localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_RESET);
    localparam int TX_DEPTH = 128;
    localparam int RX_DEPTH = 384;
    localparam int TX_CW = $clog2(TX_DEPTH + 1);
    localparam int RX_CW = $clog2(RX_DEPTH + 1);
    localparam int FRAME_W = 12;
    // Register byte addresses
    localparam logic [7:0] REG_BAUD = 8'h00;
    localparam logic [7:0] REG_TXMASK = 8'h04;
    localparam logic [7:0] REG_LINE = 8'h08;
    localparam logic [7:0] REG_ENABLE = 8'h0c;
    localparam logic [7:0] REG_ERROR = 8'h10;
    localparam logic [7:0] REG_LEVEL = 8'h14;
    // Line configuration fields
    localparam int CFG_LEN = 0;
    localparam int CFG_PAR = 2;
    localparam int CFG_PTYPE = 3;
    localparam int CFG_STOP2 = 5;
    localparam int CFG_WIDE = 6;
    localparam logic [6:0] CFG_RESET = 7'h01;
    localparam logic [1:0] LEN_7 = 2'h0;
    localparam logic [1:0] LEN_9 = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    // Manager enable fields
    localparam int EN_CHAN = 0;
    localparam int EN_TX = 1;
    localparam int EN_RX = 2;
    localparam logic [2:0] EN_RESET = 3'h7;
    // Error and status byte fields
    localparam int ERR_PAR = 0;
    localparam int ERR_BRK = 1;
    localparam int ERR_FRM = 2;
    localparam int ERR_OVR = 3;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT2 = 2'b01, TX_SHIFT = 2'b11} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_BITS = 2'b01, RX_PUSH1 = 2'b11, RX_PUSH2 = 2'b10} rx_state_t;
endpackage

// ===== hw/usb_uart_channel_datapath.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Reset gives 9600 baud, 8N1, no flow control
// - Outgoing bytes wait in a 128-byte store
// - Packet bytes leave only after good CRC
// - Shifter reloads when idle or holding a wide pair's first byte
// - Bit time from divider plus per-bit mask
// - Start, data LSB first, parity, stop bits
// - Seven or eight bits, or nine without parity
// - Nine bits without wide mode send zero
// - Wide nine-bit: two bytes form one character
// - Received characters fill a 384-byte store
// - Normal 7/8-bit mode stores only data
// - Normal 9-bit mode stores low eight bits
// - Wide 7/8-bit: data then O F B P
// - Wide 9-bit: data then O F B bit8
// - Error flags sticky until read
// - Each channel keeps its own configuration
// - Manager enables channel and its stores
module usb_uart_channel_datapath
    import uart_chan_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_end,
    input wire logic out_crc_ok,
    output logic out_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    input wire logic in_ready,
    output logic txd,
    input wire logic rxd
);
    import uart_chan_pkg::*;

    // ********************************
    // Registers
    // ********************************
    logic [15:0] baud_divider_q, mask_q;
    logic [6:0] cfg_q;
    logic [2:0] en_q;
    logic [3:0] err_q, err_set;
    logic [31:0] rdata_q, rd_mux;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    wire err_clr = rd && hit(addr, REG_ERROR);

    // One instance per channel, so every setting is private to it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_divider_q <= DIV_RESET;
            cfg_q <= CFG_RESET;
            mask_q <= '0;
        end else if (wr) begin
            if (hit(addr, REG_BAUD)) baud_divider_q <= wdata[15:0];
            if (hit(addr, REG_TXMASK)) mask_q <= wdata[15:0];
            if (hit(addr, REG_LINE)) cfg_q <= wdata[6:0];
        end
    end

    // Manager group, kept apart from the line settings
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= EN_RESET;
        end else if (wr && hit(addr, REG_ENABLE)) begin
            en_q <= wdata[2:0];
        end
    end

    // A flag raised in the clearing cycle survives the read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_q <= '0;
        end else begin
            err_q <= (err_clr ? 4'h0 : err_q) | err_set;
        end
    end

    chan_fifo_if #(.W(8), .CW(TX_CW)) txf();
    chan_fifo_if #(.W(8), .CW(RX_CW)) rxf();

    assign rd_mux = hit(addr, REG_BAUD) ? {16'h0000, baud_divider_q} :
                    hit(addr, REG_TXMASK) ? {16'h0000, mask_q} :
                    hit(addr, REG_LINE) ? {25'h0, cfg_q} :
                    hit(addr, REG_ENABLE) ? {29'h0, en_q} :
                    hit(addr, REG_ERROR) ? {28'h0, err_q} :
                    hit(addr, REG_LEVEL) ? {7'h0, rxf.level, 8'h00, txf.level} : 32'h0000_0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ********************************
    // Character format
    // ********************************
    wire [1:0] len = cfg_q[CFG_LEN +: 2];
    wire nine = len == LEN_9;
    wire seven = len == LEN_7;
    wire par_en = cfg_q[CFG_PAR] && !nine;
    wire [1:0] ptype = cfg_q[CFG_PTYPE +: 2];
    wire wide = cfg_q[CFG_WIDE];
    wire [3:0] dbits = nine ? 4'h9 : (seven ? 4'h7 : 4'h8);
    wire [3:0] rx_nbits = 4'h2 + dbits + 4'(par_en);
    wire [3:0] tx_nbits = rx_nbits + 4'(cfg_q[CFG_STOP2]);
    wire tx_on = en_q[EN_CHAN] && en_q[EN_TX];
    wire rx_on = en_q[EN_CHAN] && en_q[EN_RX];

    function automatic logic par_calc(input logic [8:0] d, input logic sev, input logic [1:0] pt);
        logic x;
        x = sev ? ^d[6:0] : ^d[7:0];
        unique case (pt)
            PAR_ODD: return ~x;
            PAR_EVEN: return x;
            PAR_MARK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Bits above the frame stay high and act as stop bits
    function automatic logic [11:0] tx_frame(input logic [8:0] d, input logic [1:0] ln,
                                             input logic pe, input logic p);
        logic [11:0] f;
        f = 12'hfff;
        if (ln == LEN_9) begin
            f[9:0] = {d, 1'b0};
        end else if (ln == LEN_7) begin
            f[8:0] = {pe ? p : 1'b1, d[6:0], 1'b0};
        end else begin
            f[9:0] = {pe ? p : 1'b1, d[7:0], 1'b0};
        end
        return f;
    endfunction

    // ********************************
    // Transmit path
    // ********************************
    tx_state_t tx_state_q;
    logic [11:0] tx_shift_reg_q;
    logic [3:0] tx_left_q, tx_idx_q;
    logic [16:0] tx_cnt_q;
    logic [7:0] tx_low_q;
    logic txd_q;

    // Packet bytes stay tentative until the packet end reports its CRC
    assign txf.wr_valid = out_valid;
    assign txf.wr_data = out_data;
    assign txf.commit = out_end && out_crc_ok;
    assign txf.abort = out_end && !out_crc_ok;
    assign txf.flush = !tx_on;

    wire tx_pair = nine && wide;
    wire tx_pop = (tx_state_q == TX_IDLE && tx_on) || tx_state_q == TX_WAIT2;
    wire tx_take = tx_pop && txf.rd_valid;
    assign txf.rd_ready = tx_pop;
    // Second byte's bit 0 is bit 8; without the pair it is forced low
    wire [8:0] tx_word = (tx_state_q == TX_WAIT2) ? {txf.rd_data[0], tx_low_q} : {1'b0, txf.rd_data};
    wire tx_load = tx_take && !(tx_state_q == TX_IDLE && tx_pair);
    wire [11:0] tx_new = tx_frame(tx_word, len, par_en, par_calc(tx_word, seven, ptype));
    wire tx_tick = tx_state_q == TX_SHIFT && tx_cnt_q == '0;
    // Mask bit of the next bit position stretches that bit by one clock
    wire [16:0] tx_reload = 17'(baud_divider_q) + 17'(mask_q[tx_idx_q + 4'h1]) - 17'h1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_q <= TX_IDLE;
            tx_shift_reg_q <= 12'hfff;
            tx_left_q <= '0;
            tx_idx_q <= '0;
            tx_cnt_q <= '0;
            tx_low_q <= '0;
            txd_q <= 1'b1;
        end else if (tx_load) begin
            tx_state_q <= TX_SHIFT;
            tx_shift_reg_q <= tx_new;
            tx_left_q <= tx_nbits;
            tx_idx_q <= '0;
            tx_cnt_q <= 17'(baud_divider_q) + 17'(mask_q[0]) - 17'h1;
            txd_q <= tx_new[0];
        end else if (tx_take) begin
            tx_state_q <= TX_WAIT2;
            tx_low_q <= txf.rd_data;
        end else if (tx_tick) begin
            tx_shift_reg_q <= {1'b1, tx_shift_reg_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
            tx_idx_q <= tx_idx_q + 4'h1;
            tx_cnt_q <= tx_reload;
            txd_q <= (tx_left_q == 4'h1) ? 1'b1 : tx_shift_reg_q[1];
            if (tx_left_q == 4'h1) tx_state_q <= TX_IDLE;
        end else if (tx_state_q == TX_SHIFT) begin
            tx_cnt_q <= tx_cnt_q - 17'h1;
        end else if (tx_state_q == TX_IDLE) begin
            txd_q <= 1'b1;
        end
    end

    // ********************************
    // Receive path
    // ********************************
    rx_state_t rx_state_q;
    logic rxd_s1, rxd_s2, rxd_s3;
    logic [11:0] rx_shift_reg_q;
    logic [3:0] rx_left_q;
    logic [16:0] rx_cnt_q;
    logic ovr_pend_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_s3 <= 1'b1;
        end else begin
            rxd_s1 <= rxd;
            rxd_s2 <= rxd_s1;
            rxd_s3 <= rxd_s2;
        end
    end

    // Realign the captured frame so the start bit sits at bit 0
    wire [11:0] rx_full = rx_shift_reg_q >> (4'hc - rx_nbits);
    wire [8:0] rx_data = nine ? rx_full[9:1] : (seven ? {2'b00, rx_full[7:1]} : {1'b0, rx_full[8:1]});
    wire rx_perr = par_en && (rx_full[dbits + 4'h1] != par_calc(rx_data, seven, ptype));
    wire rx_ferr = !rx_full[rx_nbits - 4'h1];
    wire rx_brk = rx_full == '0;
    wire [RX_CW-1:0] rx_need = wide ? RX_CW'(2) : RX_CW'(1);
    wire rx_room = rx_on && (rxf.level + rx_need <= RX_CW'(RX_DEPTH));
    wire rx_store = rx_state_q == RX_PUSH1 && rx_room;
    wire rx_drop = rx_state_q == RX_PUSH1 && !rx_room;
    wire rx_tick = rx_state_q == RX_BITS && rx_cnt_q == '0;
    // Status byte: bit 0 is parity error, or bit 8 for nine-bit characters
    wire [7:0] rx_status = {4'h0, ovr_pend_q, rx_ferr, rx_brk, nine ? rx_data[8] : rx_perr};

    // Normal mode stores the low eight bits only; errors go to the sticky flags
    assign rxf.wr_valid = rx_store || rx_state_q == RX_PUSH2;
    assign rxf.wr_data = (rx_state_q == RX_PUSH2) ? rx_status : rx_data[7:0];
    assign rxf.commit = 1'b1;
    assign rxf.abort = 1'b0;
    assign rxf.flush = !rx_on;
    assign rxf.rd_ready = in_ready;

    assign err_set = (rx_state_q == RX_PUSH1) ?
        {rx_drop, rx_ferr, rx_brk, rx_perr} : 4'h0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_q <= RX_IDLE;
            rx_shift_reg_q <= '0;
            rx_left_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    // Falling edge only, so a held break cannot restart a frame
                    if (rx_on && rxd_s3 && !rxd_s2) begin
                        rx_state_q <= RX_BITS;
                        rx_shift_reg_q <= '0;
                        rx_left_q <= rx_nbits;
                        rx_cnt_q <= {2'b00, baud_divider_q[15:1]};
                    end
                end
                RX_BITS: begin
                    if (rx_tick) begin
                        rx_shift_reg_q <= {rxd_s2, rx_shift_reg_q[11:1]};
                        rx_left_q <= rx_left_q - 4'h1;
                        rx_cnt_q <= 17'(baud_divider_q) - 17'h1;
                        if (rx_left_q == rx_nbits && rxd_s2) rx_state_q <= RX_IDLE;
                        else if (rx_left_q == 4'h1) rx_state_q <= RX_PUSH1;
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 17'h1;
                    end
                end
                RX_PUSH1: rx_state_q <= (rx_store && wide) ? RX_PUSH2 : RX_IDLE;
                RX_PUSH2: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_pend_q <= 1'b0;
        end else if (rx_drop) begin
            ovr_pend_q <= 1'b1;
        end else if (rx_state_q == RX_PUSH2) begin
            ovr_pend_q <= 1'b0;
        end
    end

    // ********************************
    // Stores
    // ********************************
    chan_fifo #(.W(8), .DEPTH(TX_DEPTH)) tx_store (.clk(clk), .resetn(resetn), .f(txf));
    chan_fifo #(.W(8), .DEPTH(RX_DEPTH)) rx_store_mem (.clk(clk), .resetn(resetn), .f(rxf));

    assign rdata = rdata_q;
    assign out_ready = txf.wr_ready;
    assign in_valid = rxf.rd_valid;
    assign in_data = rxf.rd_data;
    assign txd = txd_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_push1_wide;
        rx_store && wide;
    endsequence
    sequence s_push2_status;
        rx_state_q == RX_PUSH2 && rxf.wr_valid && rxf.wr_data[7:4] == 4'h0;
    endsequence

    chk_reset_line_defaults: assert property ($rose(resetn) |->
        baud_divider_q == DIV_RESET && cfg_q == CFG_RESET)
        else $error("line settings not at power-up defaults");
    chk_idle_mark_level: assert property ((tx_state_q == TX_IDLE)[*2] |-> txd_q)
        else $error("idle transmit line not high");
    chk_start_bit_low: assert property (tx_load |=> !txd_q && tx_state_q == TX_SHIFT)
        else $error("character did not begin with a low start bit");
    chk_nine_bit_zero: assert property (tx_load && nine && !wide |=> !tx_shift_reg_q[9])
        else $error("ninth bit not zero outside wide mode");
    chk_wide_pair_order: assert property (s_push1_wide |=> s_push2_status)
        else $error("wide mode status byte missing after data");
    chk_overrun_drop: assert property (rx_drop |-> !rxf.wr_valid ##1 err_q[ERR_OVR] && ovr_pend_q)
        else $error("dropped character did not flag overrun");
    chk_errors_sticky: assert property (!err_clr |=> (err_q & $past(err_q)) == $past(err_q))
        else $error("error flag lost without a read");
    chk_bit_period: assert property (tx_tick && tx_left_q > 4'h1 |=>
        tx_cnt_q == 17'(baud_divider_q) + 17'(mask_q[tx_idx_q]) - 17'h1)
        else $error("bit period not taken from divider and mask");
endmodule

// ===== test/serial_peer.sv
`timescale 1ns/100ps
// ****************************************
// Remote serial device on the far side
// ****************************************
module serial_peer #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    int nbits = 10;
    logic [15:0] q[$];

    initial rxd = 1'b1;

    // Samples mid-bit, start bit kept in bit 0; only the first stop bit is looked at
    always begin
        logic [15:0] v;
        @(negedge txd);
        repeat (DIV / 2) @(posedge clk);
        v = 16'h0000;
        for (int i = 0; i < nbits; i++) begin
            v[i] = txd;
            if (i < nbits - 1) repeat (DIV) @(posedge clk);
        end
        q.push_back(v);
    end

    // Start bit, then the given bits LSB first; line back at mark afterwards
    task automatic send(input int v, input int n);
        rxd <= 1'b0;
        repeat (DIV) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= v[i];
            repeat (DIV) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (2 * DIV) @(posedge clk);
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import uart_chan_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic out_valid = 1'b0;
    logic [7:0] out_data = 8'h00;
    logic out_end = 1'b0;
    logic out_crc_ok = 1'b0;
    logic in_ready = 1'b0;
    logic [31:0] rdata;
    logic out_ready, in_valid, txd, rxd;
    logic [7:0] in_data;
    int n_fail = 0;
    int checks = 0;
    int unsigned seed = 415;
    int txq[$];
    int pq[$];
    logic [8:0] rxq[$];
    int err = 0;
    bit ovr = 1'b0;
    bit hold = 1'b0;
    int txc[10] = '{8'h01, 8'h04, 8'h0c, 8'h14, 8'h1c, 8'h2d, 8'h02, 8'h06, 8'h42, 8'h41};
    int rxc[6] = '{8'h01, 8'h0c, 8'h02, 8'h4c, 8'h4d, 8'h42};

    always #2.5 clk = ~clk;

    usb_uart_channel_datapath dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .out_valid(out_valid), .out_data(out_data), .out_end(out_end), .out_crc_ok(out_crc_ok),
        .out_ready(out_ready), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .txd(txd),
        .rxd(rxd));
    serial_peer #(.DIV(16)) pmod (.clk(clk), .txd(txd), .rxd(rxd));

    // ****************************************
    // Model and comparison
    // ****************************************
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Bits after the start bit: data LSB first, parity, one stop bit
    function automatic int frm(int d, int c, bit pbad, bit sbad, output int n);
        int v;
        bit p;
        n = c[1:0] == 0 ? 7 : c[1:0] == 2 ? 9 : 8;
        v = d & ((1 << n) - 1);
        p = ^v ^ (c[4:3] == 0);
        if (c[4]) p = !c[3];
        if (c[2] && n != 9) begin
            v |= int'(p ^ pbad) << n;
            n++;
        end
        v |= int'(!sbad) << n;
        n++;
        return v;
    endfunction

    task automatic tally(bit bad, string s, int g, int e);
        checks++;
        if (bad) begin
            n_fail++;
            $display("ERROR %0t %s got %0h exp %0h", $time, s, g, e);
        end
    endtask
    task automatic cmp_reg(logic [31:0] g, logic [31:0] e);
        tally(g !== e, "reg", g, e);
    endtask
    task automatic cmp_tx(logic [15:0] g, int e);
        tally(g !== 16'(e), "tx frame", g, e);
    endtask
    task automatic cmp_rx(logic [7:0] g, logic [8:0] e);
        tally({1'b0, g} !== e, "rx byte", g, e);
    endtask

    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // Bus drivers
    // ****************************************
    task automatic wreg(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [7:0] a, logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        cmp_reg(rdata, e);
    endtask

    // Valid stays up across the packet so no signal is driven twice in one step
    task automatic put(int n, int c);
        int nn, t;
        logic [8:0] d;
        bit w9;
        w9 = c[6] && c[1:0] == 2;
        out_valid <= 1'b1;
        for (int i = 0; i < n; i++) begin
            d = 9'(rnd());
            if (!w9) d[8] = 1'b0;
            pq.push_back(frm(d, c, 1'b0, 1'b0, nn) << 1);
            pmod.nbits = nn + 1;
            for (int k = 0; k <= int'(w9); k++) begin
                out_data <= k ? {7'(rnd()), d[8]} : d[7:0];
                t = 0;
                do begin
                    @(posedge clk);
                    t++;
                end while (out_ready !== 1'b1 && t < 500);
                if (out_ready !== 1'b1) tally(1'b1, "out_ready stuck", t, 0);
            end
        end
        out_valid <= 1'b0;
    endtask
    task automatic end_pkt(bit ok);
        out_end <= 1'b1;
        out_crc_ok <= ok;
        @(posedge clk);
        out_end <= 1'b0;
        if (ok) txq = {txq, pq};
        pq = {};
    endtask
    task automatic wait_tx();
        int t;
        t = 0;
        while (pmod.q.size() < txq.size() && t < 40000) begin
            @(posedge clk);
            t++;
        end
        // Lets the last stop bits end before the format changes
        repeat (40) @(posedge clk);
        while (txq.size()) cmp_tx(pmod.q.size() ? pmod.q.pop_front() : 16'hxxxx, txq.pop_front());
        tally(pmod.q.size() != 0, "extra tx frames", pmod.q.size(), 0);
    endtask

    task automatic rx_char(int c, bit pbad, bit sbad, bit keep);
        int v, n;
        bit w9;
        v = frm(rnd() | 1, c, pbad, sbad, n);
        w9 = c[1:0] == 2;
        err |= int'(pbad && c[2] && !w9) | int'(sbad) << 2 | int'(!keep) << 3;
        if (!keep) ovr = 1'b1;
        if (keep) rxq.push_back(9'(v & (c[1:0] == 0 ? 'h7f : 'hff)));
        if (keep && c[6]) begin
            rxq.push_back({5'h00, ovr, sbad, 1'b0, w9 ? v[8] : pbad && c[2]});
            ovr = 1'b0;
        end
        pmod.send(v, n);
    endtask
    task automatic wait_rx();
        int t;
        t = 0;
        while (rxq.size() && t < 2000) begin
            @(posedge clk);
            t++;
        end
        tally(rxq.size() != 0, "rx bytes missing", rxq.size(), 0);
    endtask

    // Host stalls at random while draining
    always @(posedge clk) in_ready <= !hold && rnd() % 3 != 0;
    always @(posedge clk) begin
        if (in_valid === 1'b1 && in_ready === 1'b1) cmp_rx(in_data, rxq.size() ? rxq.pop_front() : 9'h100);
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        cmp_reg(txd, 32'h0000_0001);
        rreg(REG_BAUD, DIV_RESET);
        rreg(REG_LINE, CFG_RESET);
        rreg(REG_ENABLE, EN_RESET);
        rreg(REG_ERROR, 32'h0000_0000);
        rreg(8'h18, 32'h0000_0000);
        $display("test reset done");
        wreg(REG_BAUD, 32'h0000_0010);
        rreg(REG_TXMASK, 32'h0000_0000);
        wreg(REG_TXMASK, 32'h0000_0005);
        rreg(REG_TXMASK, 32'h0000_0005);
        put(3, 8'h01);
        end_pkt(1'b0);
        put(TX_DEPTH, 8'h01);
        repeat (3) @(posedge clk);
        cmp_reg(out_ready, 32'h0000_0000);
        rreg(REG_LEVEL, TX_DEPTH);
        end_pkt(1'b1);
        wait_tx();
        $display("test tx store done");
        foreach (txc[i]) begin
            wreg(REG_LINE, txc[i]);
            put(3, txc[i]);
            end_pkt(1'b1);
            wait_tx();
        end
        $display("test tx formats done");
        foreach (rxc[i]) begin
            wreg(REG_LINE, rxc[i]);
            err = 0;
            for (int k = 0; k < 3; k++) rx_char(rxc[i], k == 1, k == 2, 1'b1);
            wait_rx();
            rreg(REG_ERROR, err);
            rreg(REG_ERROR, 32'h0000_0000);
        end
        $display("test rx formats done");
        wreg(REG_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge clk);
        cmp_reg(out_ready, 32'h0000_0000);
        wreg(REG_LINE, 32'h0000_0041);
        // A disabled receive store ignores the line altogether
        pmod.send(32'h0000_0155, 9);
        rreg(REG_ERROR, 32'h0000_0000);
        rreg(REG_LEVEL, 32'h0000_0000);
        wreg(REG_ENABLE, EN_RESET);
        hold = 1'b1;
        err = 0;
        // 192 wide characters fill the 384-byte store; the next one is dropped
        for (int k = 0; k <= 192; k++) rx_char(8'h41, 1'b0, 1'b0, k < 192);
        rreg(REG_ERROR, err);
        hold = 1'b0;
        wait_rx();
        rx_char(8'h41, 1'b0, 1'b0, 1'b1);
        // All-zero frame: data 0, then status with framing and break
        rxq.push_back(9'h000);
        rxq.push_back(9'h006);
        pmod.send(0, 9);
        wait_rx();
        rreg(REG_ERROR, 32'h0000_0006);
        $display("test overrun done");
        final_report();
    end
endmodule
